// [include/cad_pkg.sv]
/*
 * shared types and constants of the addressing mode decoder.
 * assumes a 16-bit byte address space and 8-bit code and data memory.
 */
package cad_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // opcode layout: mode in the upper five bits, operation in the lower three
   localparam int OPC_MODE_MSB = 7;
   localparam int OPC_MODE_LSB = 3;
   localparam int OPC_OP_MSB = 2;

   // seventeen operand addressing modes
   typedef enum logic [4:0] {
      MODE_INH, MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_IDX_0, MODE_IDX_S, MODE_IDX_L,
      MODE_IND_S, MODE_IND_L, MODE_IIDX_S, MODE_IIDX_L, MODE_REL_D, MODE_REL_I,
      MODE_BIT_D, MODE_BIT_I, MODE_BTR_D, MODE_BTR_I
   } cad_mode_t;
   localparam logic [4:0] MODE_COUNT = 5'h11;

   // seven mode groups
   typedef enum logic [2:0] {
      GRP_INH, GRP_IMM, GRP_DIR, GRP_IDX, GRP_IND, GRP_REL, GRP_BIT
   } cad_grp_t;

   // inherent operations
   typedef enum logic [2:0] {
      nop_op, wait_for_irq_op, halt_op, set_irq_mask_op,
      clear_irq_mask_op, test_sign_zero_op, push_op, pop_op
   } cad_inh_t;

   // memory operations; from clear_op upward they are read-modify-write
   typedef enum logic [2:0] {
      load_op, compare_op, add_op, logic_op,
      clear_op, incdec_op, shift_op, bit_test_jump_false_op
   } cad_mop_t;

   localparam logic [1:0] NB_0 = 2'h0;
   localparam logic [1:0] NB_1 = 2'h1;
   localparam logic [1:0] NB_2 = 2'h2;
   localparam logic [2:0] LEN_OPC = 3'h1;
   localparam logic [1:0] IRQ_MASK_SET = 2'h3;
   localparam logic [1:0] IRQ_MASK_CLR = 2'h0;
   localparam logic [7:0] STACK_PAGE = 8'h01;
   localparam logic [7:0] SP_RESET = 8'hff;
   localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP = 16'h0001;

   typedef struct packed {
      cad_grp_t grp;
      logic [1:0] n_args;
      logic [1:0] n_ptr;
      logic is_long;
   } cad_info_t;

   typedef struct packed {
      cad_mode_t mode;
      logic [2:0] op;
      logic [15:0] ea;
      logic [7:0] operand;
      logic [2:0] len;
   } cad_dec_t;

   typedef enum logic [2:0] {
      ST_OP, ST_ARG, ST_PTR, ST_STACK, ST_WAIT, ST_HALT
   } cad_state_t;

   typedef struct packed {
      cad_state_t st;
      logic [15:0] pc;
      cad_mode_t mode;
      logic [2:0] op;
      cad_info_t info;
      logic [1:0] cnt;
      logic [15:0] arg;
      logic [15:0] ptr_adr;
      logic [15:0] ptr_val;
      logic [7:0] sp;
      logic [1:0] mask;
      logic flag_n;
      logic flag_z;
      logic wait_st;
      logic osc_stop;
      logic is_pop;
      logic [15:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] wdata;
      logic [7:0] pop_data;
      cad_dec_t dec;
      logic dec_valid;
      logic illegal;
   } cad_st_t;
endpackage : cad_pkg

// [design/cad_mode_info.sv]
/*
 * per-mode table: group, code bytes after the opcode, pointer bytes, long flag.
 * assumes the mode comes straight from an opcode; unknown codes give inherent.
 */
`timescale 1ns/1ps
`default_nettype none
module cad_mode_info
   import cad_pkg::*;
(
   // mode in
   input wire logic [4:0] i_mode,
   // table row out
   output cad_info_t o_info
);
   always_comb begin
      case (cad_mode_t'(i_mode))
         MODE_IMM: o_info = '{GRP_IMM, NB_1, NB_0, 1'b0};
         MODE_DIR_S: o_info = '{GRP_DIR, NB_1, NB_0, 1'b0};
         MODE_DIR_L: o_info = '{GRP_DIR, NB_2, NB_0, 1'b1};
         MODE_IDX_0: o_info = '{GRP_IDX, NB_0, NB_0, 1'b0};
         MODE_IDX_S: o_info = '{GRP_IDX, NB_1, NB_0, 1'b0};
         MODE_IDX_L: o_info = '{GRP_IDX, NB_2, NB_0, 1'b1};
         MODE_IND_S: o_info = '{GRP_IND, NB_1, NB_1, 1'b0};
         MODE_IND_L: o_info = '{GRP_IND, NB_1, NB_2, 1'b1};
         MODE_IIDX_S: o_info = '{GRP_IND, NB_1, NB_1, 1'b0};
         MODE_IIDX_L: o_info = '{GRP_IND, NB_1, NB_2, 1'b1};
         MODE_REL_D: o_info = '{GRP_REL, NB_1, NB_0, 1'b0};
         MODE_REL_I: o_info = '{GRP_REL, NB_1, NB_1, 1'b0};
         MODE_BIT_D: o_info = '{GRP_BIT, NB_1, NB_0, 1'b0};
         MODE_BIT_I: o_info = '{GRP_BIT, NB_1, NB_1, 1'b0};
         MODE_BTR_D: o_info = '{GRP_BIT, NB_2, NB_0, 1'b0};
         MODE_BTR_I: o_info = '{GRP_BIT, NB_2, NB_1, 1'b0};
         default: o_info = '{GRP_INH, NB_0, NB_0, 1'b0};
      endcase
   end
endmodule : cad_mode_info
`default_nettype wire

// [design/cad_decoder.sv]
/*
 * addressing mode decoder: fetches opcode, operand and pointer bytes, forms
 * the effective address, and carries out the inherent control operations.
 * assumes a same-clock memory that answers a held request with i_mem_valid.
 */
`timescale 1ns/1ps
`default_nettype none
module cad_decoder
   import cad_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // memory bus
   output logic [15:0] o_mem_addr,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [7:0] o_mem_wdata,
   input wire logic [7:0] i_mem_data,
   input wire logic i_mem_valid,
   // datapath inputs
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_index,
   input wire logic i_irq,
   // decoded instruction
   output cad_dec_t o_dec,
   output logic o_dec_valid,
   output logic o_illegal,
   // cpu control state
   output logic [1:0] o_irq_mask,
   output logic o_flag_n,
   output logic o_flag_z,
   output logic [7:0] o_sp,
   output logic [7:0] o_pop_data,
   output logic o_wait_st,
   output logic o_osc_stop
);
   cad_st_t q;
   cad_st_t s;
   cad_info_t info_in;
   logic [4:0] mode_in;
   logic take;

   assign mode_in = i_mem_data[OPC_MODE_MSB:OPC_MODE_LSB];
   assign take = q.st == ST_OP && i_mem_valid;

   cad_mode_info u_info (
      .i_mode(mode_in),
      .o_info(info_in)
   );

   function automatic logic [15:0] calc_ea(cad_mode_t m, logic [15:0] b, logic [7:0] x, logic [15:0] pc);
      logic [15:0] zx;
      logic [15:0] rel;
      zx = {PAGE_ZERO_HI, x};
      rel = {{8{b[7]}}, b[7:0]};
      case (m)
         MODE_IMM: calc_ea = '0;
         MODE_IDX_0: calc_ea = zx;
         MODE_IDX_S, MODE_IIDX_S: calc_ea = {PAGE_ZERO_HI, b[7:0]} + zx;
         MODE_IDX_L, MODE_IIDX_L: calc_ea = b + zx;
         MODE_DIR_L, MODE_IND_L: calc_ea = b;
         MODE_REL_D, MODE_REL_I: calc_ea = pc + rel;
         default: calc_ea = {PAGE_ZERO_HI, b[7:0]};
      endcase
   endfunction : calc_ea

   function automatic cad_st_t finish(cad_st_t c, logic [15:0] b, logic [7:0] x);
      finish = c;
      finish.st = ST_OP;
      finish.cnt = NB_0;
      finish.dec_valid = 1'b1;
      finish.dec.mode = c.mode;
      finish.dec.op = c.op;
      finish.dec.ea = calc_ea(c.mode, b, x, c.pc);
      finish.dec.operand = c.arg[7:0];
      finish.dec.len = {1'b0, c.info.n_args} + LEN_OPC;
   endfunction : finish

   always_comb begin
      s = q;
      s.dec_valid = 1'b0;
      s.illegal = 1'b0;
      case (q.st)
         ST_OP: begin
            if (i_mem_valid) begin
               s.pc = q.pc + ADDR_STEP;
               s.mode = cad_mode_t'(mode_in);
               s.op = i_mem_data[OPC_OP_MSB:0];
               s.info = info_in;
               s.cnt = NB_0;
               s.arg = '0;
               s.ptr_val = '0;
               if (mode_in >= MODE_COUNT) begin
                  s.illegal = 1'b1;
               end else if (info_in.is_long && s.op >= clear_op) begin
                  s.illegal = 1'b1;
               end else if (s.mode == MODE_INH) begin
                  s.dec = '{MODE_INH, s.op, '0, BYTE_ZERO, LEN_OPC};
                  s.dec_valid = 1'b1;
                  case (cad_inh_t'(s.op))
                     wait_for_irq_op: begin
                        s.wait_st = 1'b1;
                        s.st = ST_WAIT;
                     end
                     halt_op: begin
                        s.osc_stop = 1'b1;
                        s.st = ST_HALT;
                     end
                     set_irq_mask_op: s.mask = IRQ_MASK_SET;
                     clear_irq_mask_op: s.mask = IRQ_MASK_CLR;
                     test_sign_zero_op: begin
                        s.flag_n = i_acc[DATA_W-1];
                        s.flag_z = i_acc == BYTE_ZERO;
                     end
                     push_op: begin
                        s.wdata = i_acc;
                        s.is_pop = 1'b0;
                        s.st = ST_STACK;
                     end
                     pop_op: begin
                        s.sp = q.sp + BYTE_ONE;
                        s.is_pop = 1'b1;
                        s.st = ST_STACK;
                     end
                     default: s.st = ST_OP;
                  endcase
               end else if (info_in.n_args == NB_0) begin
                  s = finish(s, '0, i_index);
               end else begin
                  s.st = ST_ARG;
               end
            end
         end
         ST_ARG: begin
            if (i_mem_valid) begin
               s.arg = {q.arg[7:0], i_mem_data};
               s.pc = q.pc + ADDR_STEP;
               s.cnt = q.cnt + NB_1;
               if (s.cnt == q.info.n_args) begin
                  if (q.info.n_ptr != NB_0) begin
                     s.cnt = NB_0;
                     s.st = ST_PTR;
                     s.ptr_adr = {PAGE_ZERO_HI, (q.info.n_args == NB_2) ? s.arg[15:8] : s.arg[7:0]};
                  end else if (q.mode == MODE_BTR_D) begin
                     s = finish(s, {PAGE_ZERO_HI, s.arg[15:8]}, i_index);
                  end else begin
                     s = finish(s, s.arg, i_index);
                  end
               end
            end
         end
         ST_PTR: begin
            if (i_mem_valid) begin
               s.ptr_val = {q.ptr_val[7:0], i_mem_data};
               s.ptr_adr = q.ptr_adr + ADDR_STEP;
               s.cnt = q.cnt + NB_1;
               if (s.cnt == q.info.n_ptr) begin
                  s = finish(s, s.ptr_val, i_index);
               end
            end
         end
         ST_STACK: begin
            if (i_mem_valid) begin
               if (q.is_pop) begin
                  s.pop_data = i_mem_data;
               end else begin
                  s.sp = q.sp - BYTE_ONE;
               end
               s.st = ST_OP;
            end
         end
         ST_WAIT: begin
            if (i_irq) begin
               s.wait_st = 1'b0;
               s.st = ST_OP;
            end
         end
         ST_HALT: begin
            if (i_irq) begin
               s.osc_stop = 1'b0;
               s.st = ST_OP;
            end
         end
         default: s.st = ST_OP;
      endcase
      // bus request follows the next state
      s.mem_rd = s.st == ST_OP || s.st == ST_ARG || s.st == ST_PTR || (s.st == ST_STACK && s.is_pop);
      s.mem_wr = s.st == ST_STACK && !s.is_pop;
      if (s.st == ST_PTR) begin
         s.mem_addr = s.ptr_adr;
      end else if (s.st == ST_STACK) begin
         s.mem_addr = {STACK_PAGE, s.sp};
      end else begin
         s.mem_addr = s.pc;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         q <= '0;
         q.pc <= PC_RESET;
         q.sp <= SP_RESET;
         q.mask <= IRQ_MASK_SET;
      end else begin
         q <= s;
      end
   end

   assign o_mem_addr = q.mem_addr;
   assign o_mem_rd = q.mem_rd;
   assign o_mem_wr = q.mem_wr;
   assign o_mem_wdata = q.wdata;
   assign o_dec = q.dec;
   assign o_dec_valid = q.dec_valid;
   assign o_illegal = q.illegal;
   assign o_irq_mask = q.mask;
   assign o_flag_n = q.flag_n;
   assign o_flag_z = q.flag_z;
   assign o_sp = q.sp;
   assign o_pop_data = q.pop_data;
   assign o_wait_st = q.wait_st;
   assign o_osc_stop = q.osc_stop;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_take_inh(cad_inh_t o);
      take && mode_in == MODE_INH && i_mem_data[OPC_OP_MSB:0] == o;
   endsequence

   sequence s_last_arg(cad_mode_t m);
      q.st == ST_ARG && i_mem_valid && q.mode == m && q.cnt + NB_1 == q.info.n_args;
   endsequence

   a_bad_mode_code: assert property (take && mode_in >= MODE_COUNT |=> o_illegal && !o_dec_valid)
      else $error("unknown mode code not flagged");
   a_inh_one_byte: assert property (s_take_inh(nop_op) |=> o_dec_valid && o_dec.len == LEN_OPC && o_mem_rd
      && o_mem_addr == $past(q.pc) + ADDR_STEP)
      else $error("inherent op not one byte");
   a_long_direct: assert property (s_last_arg(MODE_DIR_L) |=> o_dec_valid && o_dec.len == 3'h3
      && o_dec.ea == {$past(q.arg[7:0]), $past(i_mem_data)})
      else $error("long direct address wrong");
   a_short_direct: assert property (s_last_arg(MODE_DIR_S) |=> o_dec_valid && o_dec.len == 3'h2
      && o_dec.ea == {PAGE_ZERO_HI, $past(i_mem_data)})
      else $error("short direct address wrong");
   a_rmw_long_refused: assert property (take && info_in.is_long && i_mem_data[OPC_OP_MSB:0] >= clear_op
      |=> o_illegal && !o_dec_valid)
      else $error("long rmw not refused");
   a_wait_holds: assert property (s_take_inh(wait_for_irq_op) ##1 !i_irq[*2] |-> o_wait_st && !o_mem_rd)
      else $error("wait state left early");
   a_halt_stops: assert property (s_take_inh(halt_op) |=> o_osc_stop && !o_mem_rd)
      else $error("halt did not stop oscillator");
   a_mask_set: assert property (s_take_inh(set_irq_mask_op) |=> o_irq_mask == IRQ_MASK_SET)
      else $error("mask not level three");
   a_mask_clear: assert property (s_take_inh(clear_irq_mask_op) |=> o_irq_mask == IRQ_MASK_CLR)
      else $error("mask not level zero");
   a_test_flags: assert property (s_take_inh(test_sign_zero_op) |=> o_flag_z == ($past(i_acc) == BYTE_ZERO)
      && o_flag_n == $past(i_acc[7]) && o_sp == $past(o_sp))
      else $error("test flags wrong");
   a_push_stack: assert property (s_take_inh(push_op) |=> o_mem_wr && o_mem_addr == {STACK_PAGE, $past(o_sp)}
      && o_mem_wdata == $past(i_acc))
      else $error("push write wrong");
   a_pop_stack: assert property (s_take_inh(pop_op) |=> o_mem_rd && o_sp == $past(o_sp) + BYTE_ONE)
      else $error("pop pointer wrong");
   a_arg_from_pc: assert property (q.st == ST_ARG |-> o_mem_rd && o_mem_addr == q.pc && !o_dec_valid)
      else $error("operand not fetched from code");
endmodule : cad_decoder
`default_nettype wire

// [test/cad_mem_model.sv]
/*
 * program and data memory model on the decoder's bus.
 * assumes one clock, a request held until answered, and the bench preloading mem.
 */
`timescale 1ns/1ps
`default_nettype none
module cad_mem_model
   import cad_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // request side
   input wire logic [15:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic [1:0] i_lat,
   // answer side
   output logic [7:0] o_data,
   output logic o_valid
);
   logic [7:0] mem [0:65535];
   logic [7:0] data_q;
   logic [1:0] cnt_q;

   // released data lines show the inverse of the last byte
   assign o_data = o_valid ? data_q : ~data_q;

   // answer after i_lat idle cycles, one pulse per request
   always @(posedge i_sys_clk) begin
      o_valid <= 1'b0;
      if (i_rst) begin
         cnt_q <= 2'h0;
         data_q <= 8'h00;
      end else if ((i_rd || i_wr) && !o_valid) begin
         if (cnt_q >= i_lat) begin
            o_valid <= 1'b1;
            cnt_q <= 2'h0;
            data_q <= mem[i_addr];
            if (i_wr) begin
               mem[i_addr] <= i_wdata;
            end
         end else begin
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end
endmodule : cad_mem_model
`default_nettype wire

// [test/tb.sv]
/*
 * self-checking bench for the addressing mode decoder: one preloaded program.
 * assumes the memory model answers promptly first, then with two idle cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cad_pkg::*;
   logic i_sys_clk, i_rst, i_irq, mem_rd, mem_wr, mem_valid, dec_valid, illegal;
   logic flag_n, flag_z, wait_st, osc_stop;
   logic [7:0] i_acc, i_index, mem_wdata, mem_data, sp, pop_data;
   logic [15:0] mem_addr;
   logic [1:0] lat, irq_mask;
   cad_dec_t dec;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] prog [0:45] = '{8'h18, 8'h12, 8'h34, 8'h14, 8'h80, 8'h1c, 8'h29, 8'hf0, 8'h40, 8'h30, 8'h58,
      8'hfe, 8'h08, 8'h55, 8'h78, 8'h40, 8'h05, 8'h88, 8'h04, 8'h03, 8'h05, 8'h06, 8'h07, 8'h01, 8'h02, 8'h00,
      8'h20, 8'h30, 8'h12, 8'h00, 8'h38, 8'h30, 8'h48, 8'h30, 8'h50, 8'h30, 8'h60, 8'h31, 8'h68, 8'h40, 8'h70,
      8'h30, 8'h80, 8'h31, 8'h07, 8'h34};

   cad_decoder dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd),
      .o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata), .i_mem_data(mem_data), .i_mem_valid(mem_valid),
      .i_acc(i_acc), .i_index(i_index), .i_irq(i_irq), .o_dec(dec), .o_dec_valid(dec_valid),
      .o_illegal(illegal), .o_irq_mask(irq_mask), .o_flag_n(flag_n), .o_flag_z(flag_z), .o_sp(sp),
      .o_pop_data(pop_data), .o_wait_st(wait_st), .o_osc_stop(osc_stop));
   cad_mem_model mem (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(mem_addr), .i_rd(mem_rd), .i_wr(mem_wr),
      .i_wdata(mem_wdata), .i_lat(lat), .o_data(mem_data), .o_valid(mem_valid));

   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   task automatic end_of_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_dec(input cad_dec_t exp);
      total_checks++;
      if (dec !== exp) begin
         error_cnt++;
         $display("FAIL %0t decode got %h exp %h", $time, dec, exp);
      end
   endtask : chk_dec

   task automatic chk_inh(input logic [2:0] op);
      chk_val({5'h0, dec.mode, dec.op, dec.len}, {5'h0, MODE_INH, op, LEN_OPC}, "inherent decode");
   endtask : chk_inh

   // timeout: count it and close the run
   task automatic bail(input string what);
      error_cnt++;
      $display("FAIL %0t %s", $time, what);
      end_of_test();
   endtask : bail

   // bounded wait for the next decode or refusal pulse
   task automatic next_dec(input logic exp_ill);
      int n;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end while (dec_valid !== 1'b1 && illegal !== 1'b1 && n < 60);
      if (dec_valid !== 1'b1 && illegal !== 1'b1) begin
         bail("no decode pulse");
      end
      chk_val({14'h0, illegal, dec_valid}, {14'h0, exp_ill, ~exp_ill}, "pulse kind");
   endtask : next_dec

   task automatic sc_reset();
      #1;
      chk_val({8'h0, sp}, {8'h0, SP_RESET}, "reset sp");
      chk_val({12'h0, irq_mask, wait_st, osc_stop}, 16'h000c, "reset mask");
   endtask : sc_reset

   task automatic sc_long_short();
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_DIR_L, 3'h0, 16'h1234, 8'h34, 3'h3});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_DIR_S, 3'h4, 16'h0080, 8'h80, 3'h2});
      next_dec(1'b1);
   endtask : sc_long_short

   task automatic sc_modes();
      @(posedge i_sys_clk);
      lat <= 2'h2;
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IDX_S, 3'h1, 16'h0110, 8'hf0, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IND_L, 3'h0, 16'habcd, 8'h30, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_REL_D, 3'h0, 16'h000a, 8'hfe, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IMM, 3'h0, 16'h0000, 8'h55, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_BTR_D, 3'h0, 16'h0040, 8'h05, 3'h3});
      next_dec(1'b1);
   endtask : sc_modes

   task automatic sc_mask_test();
      next_dec(1'b0);
      chk_inh(clear_irq_mask_op);
      chk_val({14'h0, irq_mask}, {14'h0, IRQ_MASK_CLR}, "mask clear");
      next_dec(1'b0);
      chk_inh(set_irq_mask_op);
      chk_val({14'h0, irq_mask}, {14'h0, IRQ_MASK_SET}, "mask set");
      next_dec(1'b0);
      chk_inh(test_sign_zero_op);
      chk_val({14'h0, flag_n, flag_z}, 16'h0002, "sign zero");
   endtask : sc_mask_test

   task automatic sc_stack();
      int n;
      next_dec(1'b0);
      chk_inh(push_op);
      chk_val({mem_wr, 7'h0, mem_wdata}, 16'h8080, "push write");
      chk_val(mem_addr, 16'h01ff, "push addr");
      for (n = 0; n < 20 && mem_wr === 1'b1; n++) begin
         @(posedge i_sys_clk);
         #1;
      end
      if (mem_wr === 1'b1) begin
         bail("push not completed");
      end
      chk_val({8'h0, sp}, 16'h00fe, "sp after push");
      next_dec(1'b0);
      chk_inh(pop_op);
      chk_val({8'h0, sp}, 16'h00ff, "sp after pop");
      for (n = 0; n < 20 && pop_data !== 8'h80; n++) begin
         @(posedge i_sys_clk);
         #1;
      end
      if (n == 20) begin
         bail("pop not completed");
      end
      chk_val({pop_data, mem.mem[16'h01ff]}, 16'h8080, "pop data");
   endtask : sc_stack

   task automatic sc_sleep();
      for (int k = 0; k < 2; k++) begin
         next_dec(1'b0);
         chk_inh(k ? halt_op : wait_for_irq_op);
         repeat (6) begin
            @(posedge i_sys_clk);
            #1;
            chk_val({14'h0, (k ? osc_stop : wait_st), mem_rd}, 16'h0002, "sleep hold");
         end
         @(posedge i_sys_clk);
         i_irq <= 1'b1;
         @(posedge i_sys_clk);
         i_irq <= 1'b0;
         #1;
         chk_val({14'h0, wait_st, osc_stop}, 16'h0000, "wake");
      end
      next_dec(1'b0);
      chk_inh(nop_op);
   endtask : sc_sleep

   task automatic sc_more_modes();
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IDX_0, 3'h0, 16'h0020, 8'h00, 3'h1});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IDX_L, 3'h0, 16'h1220, 8'h00, 3'h3});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IND_S, 3'h0, 16'h00ab, 8'h30, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IIDX_S, 3'h0, 16'h00cb, 8'h30, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_IIDX_L, 3'h0, 16'habed, 8'h30, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_REL_I, 3'h0, 16'hfff3, 8'h31, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_BIT_D, 3'h0, 16'h0040, 8'h40, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_BIT_I, 3'h0, 16'h00ab, 8'h30, 3'h2});
      next_dec(1'b0);
      chk_dec(cad_dec_t'{MODE_BTR_I, 3'h0, 16'h00cd, 8'h07, 3'h3});
      next_dec(1'b1);
   endtask : sc_more_modes

   initial begin
      i_rst = 1'b1;
      i_irq = 1'b0;
      i_acc = 8'h80;
      i_index = 8'h20;
      lat = 2'h0;
      for (int a = 0; a < 65536; a++) begin
         mem.mem[a] = 8'h00;
      end
      for (int a = 0; a < 46; a++) begin
         mem.mem[a] = prog[a];
      end
      mem.mem[16'h0030] = 8'hab;
      mem.mem[16'h0031] = 8'hcd;
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      sc_reset();
      sc_long_short();
      sc_modes();
      sc_mask_test();
      sc_stack();
      sc_sleep();
      sc_more_modes();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
